//--- dfatd_map.svh
// Constants for the drive fault auto-reset and torque detection block
`ifndef DFATD_MAP_SVH
`define DFATD_MAP_SVH

`define DFATD_CLK_PERIOD_NS  10
// Base tick of 0.1 s for all protection timers
`define DFATD_TICK_TIME_NS   100000000
`define DFATD_TICK_CYCLES    (`DFATD_TICK_TIME_NS / `DFATD_CLK_PERIOD_NS)
`define DFATD_TICKS_PER_S    (1000000000 / `DFATD_TICK_TIME_NS)
// Fault-free run time that clears the attempt counter
`define DFATD_CLEAR_TIME_S   600
`define DFATD_CLEAR_TICKS    (`DFATD_CLEAR_TIME_S * `DFATD_TICKS_PER_S)

`define DFATD_HYST_PCT       11'h00A
`define DFATD_SEL_MAX        4'h8
`define DFATD_SEL_UNDER_MIN  4'h5
`define DFATD_CNT_MAX        4'hF

// Output terminal function codes
`define DFATD_FN_FAULT       8'h0E
`define DFATD_FN_TQ1         8'h0B
`define DFATD_FN_TQ2         8'h18
`define DFATD_FN_RESET       8'h1E

`endif

//--- dfatd_pkg.sv
// Types shared by the drive protection block
package dfatd_pkg;
    typedef enum logic [2:0] {
        ST_RUN    = 3'b001,
        ST_WAIT   = 3'b010,
        ST_MANUAL = 3'b100
    } dfatd_state_t;
endpackage

//--- dfatd_tick.sv
// Divider producing the 0.1 s timer enable pulse
`timescale 1ns/1ps
`default_nettype none
module dfatd_tick #(
    parameter int unsigned CYCLES = 10
) (
    input  wire logic clk_i,   // System clock
    input  wire logic srst_i,  // Sync reset
    output logic      tick_o   // One-cycle enable
);
    logic [23:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (srst_i || cnt_q == 24'(CYCLES - 1)) begin
            cnt_q <= 24'h000000;
        end else begin
            cnt_q <= cnt_q + 24'h000001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= (cnt_q == 24'(CYCLES - 1));
        end
    end
endmodule
`default_nettype wire

//--- dfatd_torque_ch.sv
// One over/undertorque detection channel
`timescale 1ns/1ps
`default_nettype none
`include "dfatd_map.svh"
module dfatd_torque_ch (
    input  wire logic       clk_i,          // System clock
    input  wire logic       srst_i,         // Sync reset
    input  wire logic       tick_i,         // 0.1 s enable
    input  wire logic       vf_mode_i,      // V/f control mode
    input  wire logic       travel_i,       // Up or down command active
    input  wire logic       speed_agree_i,  // Speed equals reference
    input  wire logic [3:0] sel_i,          // Selection 0..8
    input  wire logic [8:0] level_i,        // Level, percent
    input  wire logic [6:0] time_i,         // Time, 0.1 s units
    input  wire logic [9:0] current_pct_i,  // Current, % drive rated
    input  wire logic [9:0] torque_pct_i,   // Torque, % motor rated
    output logic            detect_o,       // Condition detected
    output logic            under_o,        // Detected as undertorque
    output logic            fault_o         // Detected with fault action
);
    logic        det_q;
    logic [6:0]  cnt_q;
    logic [10:0] val;
    logic [10:0] lvl;
    logic        under;
    logic        enable;
    logic        beyond;
    logic        release_c;

    assign val = {1'b0, vf_mode_i ? current_pct_i : torque_pct_i};
    assign lvl = {2'b00, level_i};
    assign under = (sel_i >= `DFATD_SEL_UNDER_MIN);
    // Odd selections wait for speed agree
    assign enable = (sel_i != 4'h0) && (sel_i <= `DFATD_SEL_MAX) && travel_i
                    && (!sel_i[0] || speed_agree_i);
    assign beyond = under ? (val < lvl) : (val > lvl);
    assign release_c = under ? (val > lvl + `DFATD_HYST_PCT)
                             : (val + `DFATD_HYST_PCT < lvl);

    always_ff @(posedge clk_i) begin
        if (srst_i || !enable || !beyond || det_q) begin
            cnt_q <= 7'h00;
        end else if (tick_i && cnt_q != 7'h7F) begin
            cnt_q <= cnt_q + 7'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || !enable) begin
            det_q <= 1'b0;
        end else if (det_q && release_c) begin
            det_q <= 1'b0;
        end else if (!det_q && beyond && tick_i && cnt_q >= time_i) begin
            det_q <= 1'b1;
        end
    end

    assign detect_o = det_q;
    assign under_o  = det_q && under;
    assign fault_o  = det_q && (sel_i == 4'h3 || sel_i == 4'h4 ||
                                sel_i == 4'h7 || sel_i == 4'h8);

    persist_rise_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(det_q) |-> $past(beyond) && $past(cnt_q) >= $past(time_i))
        else $error("torque detect rose before persistence time");
    hyst_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        det_q && enable && !release_c ##1 enable |-> det_q)
        else $error("torque detect released inside hysteresis band");
endmodule
`default_nettype wire

//--- dfatd_top.sv
// Drive fault auto-reset sequencer with two torque detection channels
`timescale 1ns/1ps
`default_nettype none
`include "dfatd_map.svh"
module dfatd_top #(
    parameter int unsigned TICK_CYCLES = `DFATD_TICK_CYCLES
) (
    input  wire logic        clk_i,                          // 100 MHz clock
    input  wire logic        srst_i,                         // Sync reset, power-on
    input  wire logic        ground_fault_i,                 // Resettable fault
    input  wire logic        output_phase_loss_fault_i,      // Resettable fault
    input  wire logic        overcurrent_fault_i,            // Resettable fault
    input  wire logic        heatsink_overheat_fault_i,      // Resettable fault
    input  wire logic        motor_overload_fault_i,         // Resettable fault
    input  wire logic        drive_overload_fault_i,         // Resettable fault
    input  wire logic        dc_bus_overvoltage_fault_i,     // Resettable fault
    input  wire logic        braking_transistor_fault_i,     // Resettable fault
    input  wire logic        sequence_error_one_i,           // Resettable fault
    input  wire logic        sequence_error_two_i,           // Resettable fault
    input  wire logic        sequence_error_three_i,         // Resettable fault
    input  wire logic        dc_bus_undervoltage_fault_i,    // Undervoltage fault
    input  wire logic        other_fault_i,                  // Any non-resettable fault
    input  wire logic        manual_fault_reset_i,           // External fault reset
    input  wire logic        up_cmd_i,                       // Up travel command
    input  wire logic        down_cmd_i,                     // Down travel command
    input  wire logic        speed_agree_i,                  // Speed equals reference
    input  wire logic        vf_mode_i,                      // 1 V/f, 0 vector
    input  wire logic [9:0]  current_pct_i,                  // Output current, %
    input  wire logic [9:0]  torque_pct_i,                   // Output torque, %
    input  wire logic [3:0]  reset_attempt_limit_i,          // 0..10
    input  wire logic        fault_output_during_reset_sel_i,// Fault out in reset
    input  wire logic [12:0] reset_interval_time_i,          // 0.1 s units
    input  wire logic        undervoltage_reset_policy_i,    // 1 unlimited
    input  wire logic [3:0]  torque_detect_select_ch1_i,     // 0..8
    input  wire logic [3:0]  torque_detect_select_ch2_i,     // 0..8
    input  wire logic [8:0]  torque_detect_level_ch1_i,      // 0..300 %
    input  wire logic [8:0]  torque_detect_level_ch2_i,      // 0..300 %
    input  wire logic [6:0]  torque_detect_time_ch1_i,       // 0.1 s units
    input  wire logic [6:0]  torque_detect_time_ch2_i,       // 0.1 s units
    input  wire logic [7:0]  output_terminal_function_sel0_i,// Terminal 0 code
    input  wire logic [7:0]  output_terminal_function_sel1_i,// Terminal 1 code
    output logic             output_terminal0_o,             // Terminal 0, 1 closed
    output logic             output_terminal1_o,             // Terminal 1, 1 closed
    output logic             drive_stop_o,                   // Operation stopped
    output logic             fault_locked_o,                 // Manual reset needed
    output logic [3:0]       reset_attempt_count_o,          // Attempt counter
    output logic             overtorque_event_ch1_o,         // Channel 1 over
    output logic             overtorque_event_ch2_o,         // Channel 2 over
    output logic             undertorque_event_ch1_o,        // Channel 1 under
    output logic             undertorque_event_ch2_o         // Channel 2 under
);
    dfatd_pkg::dfatd_state_t state_q;
    logic        tick;
    logic [3:0]  cnt_q;
    logic [12:0] ivl_q;
    logic [12:0] clr_q;
    logic        clr_arm_q;
    logic [1:0]  term_q;
    logic [1:0]  tq_det;
    logic [1:0]  tq_under;
    logic [1:0]  tq_fault;
    logic [3:0]  ch_sel   [2];
    logic [8:0]  ch_level [2];
    logic [6:0]  ch_time  [2];
    logic [7:0]  term_code [2];
    logic        resettable;
    logic        any_flt;
    logic        uv_free;
    logic        lock_now;
    logic        elapsed;
    logic        auto_ok;
    logic        auto_go;
    logic        clr_done;
    logic        in_wait;
    logic        fault_sig;

    function automatic logic term_fn(input logic [7:0] code, input logic flt,
                                     input logic rst, input logic [1:0] tq);
        case (code)
            `DFATD_FN_FAULT: term_fn = flt;
            `DFATD_FN_RESET: term_fn = rst;
            `DFATD_FN_TQ1:   term_fn = tq[0];
            `DFATD_FN_TQ2:   term_fn = tq[1];
            default:         term_fn = 1'b0;
        endcase
    endfunction

    dfatd_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .tick_o (tick)
    );

    assign ch_sel[0]   = torque_detect_select_ch1_i;
    assign ch_sel[1]   = torque_detect_select_ch2_i;
    assign ch_level[0] = torque_detect_level_ch1_i;
    assign ch_level[1] = torque_detect_level_ch2_i;
    assign ch_time[0]  = torque_detect_time_ch1_i;
    assign ch_time[1]  = torque_detect_time_ch2_i;
    assign term_code[0] = output_terminal_function_sel0_i;
    assign term_code[1] = output_terminal_function_sel1_i;

    for (genvar g = 0; g < 2; g++) begin : g_ch
        dfatd_torque_ch u_ch (
            .clk_i         (clk_i),
            .srst_i        (srst_i),
            .tick_i        (tick),
            .vf_mode_i     (vf_mode_i),
            .travel_i      (up_cmd_i || down_cmd_i),
            .speed_agree_i (speed_agree_i),
            .sel_i         (ch_sel[g]),
            .level_i       (ch_level[g]),
            .time_i        (ch_time[g]),
            .current_pct_i (current_pct_i),
            .torque_pct_i  (torque_pct_i),
            .detect_o      (tq_det[g]),
            .under_o       (tq_under[g]),
            .fault_o       (tq_fault[g])
        );
    end

    assign overtorque_event_ch1_o  = tq_det[0] && !tq_under[0];
    assign overtorque_event_ch2_o  = tq_det[1] && !tq_under[1];
    assign undertorque_event_ch1_o = tq_under[0];
    assign undertorque_event_ch2_o = tq_under[1];

    assign resettable = ground_fault_i | output_phase_loss_fault_i
                      | overcurrent_fault_i | heatsink_overheat_fault_i
                      | motor_overload_fault_i | drive_overload_fault_i
                      | dc_bus_overvoltage_fault_i | braking_transistor_fault_i
                      | sequence_error_one_i | sequence_error_two_i
                      | sequence_error_three_i | (|tq_fault);
    assign any_flt = resettable | dc_bus_undervoltage_fault_i | other_fault_i;
    // Unlimited only when undervoltage is the sole cause
    assign uv_free = dc_bus_undervoltage_fault_i && !resettable
                     && undervoltage_reset_policy_i;
    // Limit zero makes cnt_q >= limit always true
    assign lock_now = other_fault_i
                      || (cnt_q >= reset_attempt_limit_i && !uv_free);

    assign in_wait  = (state_q == dfatd_pkg::ST_WAIT);
    assign elapsed  = (reset_interval_time_i == 13'h0000)
                      || (ivl_q >= reset_interval_time_i);
    // Reset only once the cause is gone and travel commands are off
    assign auto_ok  = elapsed && !up_cmd_i && !down_cmd_i && !any_flt;
    assign auto_go  = in_wait && auto_ok && !manual_fault_reset_i;
    assign clr_done = clr_arm_q && tick && clr_q == 13'(`DFATD_CLEAR_TICKS - 1);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= dfatd_pkg::ST_RUN;
        end else begin
            unique case (state_q)
                dfatd_pkg::ST_RUN: begin
                    if (any_flt) begin
                        state_q <= lock_now ? dfatd_pkg::ST_MANUAL : dfatd_pkg::ST_WAIT;
                    end
                end
                dfatd_pkg::ST_WAIT: begin
                    if (manual_fault_reset_i) begin
                        state_q <= dfatd_pkg::ST_RUN;
                    end else if (other_fault_i) begin
                        state_q <= dfatd_pkg::ST_MANUAL;
                    end else if (auto_ok) begin
                        state_q <= dfatd_pkg::ST_RUN;
                    end
                end
                dfatd_pkg::ST_MANUAL: begin
                    if (manual_fault_reset_i) begin
                        state_q <= dfatd_pkg::ST_RUN;
                    end
                end
                default: state_q <= dfatd_pkg::ST_RUN;
            endcase
        end
    end

    // Interval restarts while the fault persists past each attempt
    always_ff @(posedge clk_i) begin
        if (srst_i || !in_wait || (elapsed && any_flt)) begin
            ivl_q <= 13'h0000;
        end else if (tick && !elapsed) begin
            ivl_q <= ivl_q + 13'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_q <= 4'h0;
        end else if (manual_fault_reset_i) begin
            cnt_q <= 4'h0;
        end else if (auto_go) begin
            if (cnt_q != `DFATD_CNT_MAX) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end else if (clr_done) begin
            cnt_q <= 4'h0;
        end
    end

    // Fault-free timer armed by each automatic reset
    always_ff @(posedge clk_i) begin
        if (srst_i || any_flt || state_q != dfatd_pkg::ST_RUN && !auto_go) begin
            clr_arm_q <= 1'b0;
            clr_q     <= 13'h0000;
        end else if (auto_go) begin
            clr_arm_q <= 1'b1;
            clr_q     <= 13'h0000;
        end else if (clr_done) begin
            clr_arm_q <= 1'b0;
        end else if (clr_arm_q && tick) begin
            clr_q <= clr_q + 13'h0001;
        end
    end

    assign fault_sig = (state_q == dfatd_pkg::ST_MANUAL)
                       || (in_wait && fault_output_during_reset_sel_i);

    for (genvar t = 0; t < 2; t++) begin : g_term
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                term_q[t] <= 1'b0;
            end else begin
                term_q[t] <= term_fn(term_code[t], fault_sig, in_wait, tq_det);
            end
        end
    end

    assign output_terminal0_o    = term_q[0];
    assign output_terminal1_o    = term_q[1];
    assign drive_stop_o          = (state_q != dfatd_pkg::ST_RUN);
    assign fault_locked_o        = (state_q == dfatd_pkg::ST_MANUAL);
    assign reset_attempt_count_o = cnt_q;

    hard_lock_a: assert property (@(posedge clk_i) disable iff (srst_i)
        state_q == dfatd_pkg::ST_RUN && other_fault_i
        |=> state_q == dfatd_pkg::ST_MANUAL)
        else $error("non-resettable fault not latched");
    count_inc_a: assert property (@(posedge clk_i) disable iff (srst_i)
        auto_go && cnt_q != 4'hF |=> cnt_q == $past(cnt_q) + 4'h1
        && state_q == dfatd_pkg::ST_RUN)
        else $error("attempt counter not incremented on auto reset");
    limit_stop_a: assert property (@(posedge clk_i) disable iff (srst_i)
        state_q == dfatd_pkg::ST_RUN && resettable && !manual_fault_reset_i
        && cnt_q >= reset_attempt_limit_i |=> state_q == dfatd_pkg::ST_MANUAL)
        else $error("auto reset attempted beyond limit");
    zero_limit_a: assert property (@(posedge clk_i) disable iff (srst_i)
        state_q == dfatd_pkg::ST_RUN && any_flt && !uv_free
        && reset_attempt_limit_i == 4'h0 |=> state_q == dfatd_pkg::ST_MANUAL)
        else $error("auto reset with zero attempt limit");
    ten_min_a: assert property (@(posedge clk_i) disable iff (srst_i)
        clr_done && !manual_fault_reset_i |=> cnt_q == 4'h0 && !clr_arm_q)
        else $error("counter not cleared after fault-free period");
    manual_clr_a: assert property (@(posedge clk_i) disable iff (srst_i)
        manual_fault_reset_i |=> cnt_q == 4'h0)
        else $error("manual reset did not clear counter");
    power_clr_a: assert property (@(posedge clk_i)
        srst_i |=> cnt_q == 4'h0 && state_q == dfatd_pkg::ST_RUN)
        else $error("reset did not clear counter");
    cmd_block_a: assert property (@(posedge clk_i) disable iff (srst_i)
        in_wait && (up_cmd_i || down_cmd_i) && !manual_fault_reset_i
        |=> state_q != dfatd_pkg::ST_RUN)
        else $error("auto reset while travel command active");
    interval_a: assert property (@(posedge clk_i) disable iff (srst_i)
        in_wait && !manual_fault_reset_i && reset_interval_time_i != 13'h0000
        && ivl_q < reset_interval_time_i |=> state_q != dfatd_pkg::ST_RUN)
        else $error("reset before interval elapsed");
    reset_term_a: assert property (@(posedge clk_i) disable iff (srst_i)
        in_wait && term_code[0] == `DFATD_FN_RESET |=> output_terminal0_o)
        else $error("reset-enabled terminal not asserted");
    fault_term_a: assert property (@(posedge clk_i) disable iff (srst_i)
        in_wait && term_code[1] == `DFATD_FN_FAULT
        |=> output_terminal1_o == $past(fault_output_during_reset_sel_i))
        else $error("fault terminal ignores reset output selection");

    auto_reset_c: cover property (@(posedge clk_i) disable iff (srst_i) auto_go);
    lock_c: cover property (@(posedge clk_i) disable iff (srst_i)
        state_q == dfatd_pkg::ST_RUN && resettable && lock_now);
    ten_min_c: cover property (@(posedge clk_i) disable iff (srst_i) clr_done);
    torque_c: cover property (@(posedge clk_i) disable iff (srst_i) |tq_fault);
endmodule
`default_nettype wire

//--- dfatd_ctrl_model.sv
// Elevator controller model that owns the travel commands
`timescale 1ns/1ps
`default_nettype none
module dfatd_ctrl_model (
    input  wire logic clk_i,      // System clock
    input  wire logic run_i,      // Travel wanted
    input  wire logic dir_i,      // 1 up, 0 down
    input  wire logic stop_i,     // Drive reports stop
    output logic      up_cmd_o,   // Up travel command
    output logic      down_cmd_o  // Down travel command
);
    logic [1:0] lag_q;
    // Reacts late on purpose so a reset must wait for the commands to drop
    always_ff @(posedge clk_i) begin
        lag_q <= !stop_i ? 2'h0 : (lag_q == 2'h3) ? lag_q : lag_q + 2'h1;
    end
    assign up_cmd_o   = run_i && dir_i && lag_q != 2'h3;
    assign down_cmd_o = run_i && !dir_i && lag_q != 2'h3;
endmodule
`default_nettype wire

//--- dfatd_top_test.sv
// Self-checking bench for the drive protection block
`timescale 1ns/1ps
`default_nettype none
module dfatd_top_test;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [10:0] rf = 11'h000;
    logic        uv, oth, mrst, run, spd, vf, fsel, uvp, dir;
    logic        up, dn, t0, t1, stp, lck, ov1, ov2, un1, un2;
    logic [9:0]  cur, trq;
    logic [9:0]  off [4] = '{10'h00A, 10'h00A, 10'h3FB, 10'h3F5};
    logic [3:0]  lim, sel1, sel2, cnt;
    logic [12:0] iv;
    logic [8:0]  lvl;
    logic [7:0]  fn1;
    int          failures = 0;
    int          check_count = 0;
    int          seed = 32'h0EF7;

    always #5 clk_i = ~clk_i;

    dfatd_ctrl_model dfatd_ctrl_model_inst (.clk_i(clk_i), .run_i(run), .dir_i(dir), .stop_i(stp),
        .up_cmd_o(up), .down_cmd_o(dn));

    dfatd_top #(.TICK_CYCLES(4)) dfatd_top_inst (.clk_i(clk_i), .srst_i(srst_i),
        .ground_fault_i(rf[0]), .output_phase_loss_fault_i(rf[1]), .overcurrent_fault_i(rf[2]),
        .heatsink_overheat_fault_i(rf[3]), .motor_overload_fault_i(rf[4]), .drive_overload_fault_i(rf[5]),
        .dc_bus_overvoltage_fault_i(rf[6]), .braking_transistor_fault_i(rf[7]), .sequence_error_one_i(rf[8]),
        .sequence_error_two_i(rf[9]), .sequence_error_three_i(rf[10]), .dc_bus_undervoltage_fault_i(uv),
        .other_fault_i(oth), .manual_fault_reset_i(mrst), .up_cmd_i(up), .down_cmd_i(dn),
        .speed_agree_i(spd), .vf_mode_i(vf), .current_pct_i(cur), .torque_pct_i(trq),
        .reset_attempt_limit_i(lim), .fault_output_during_reset_sel_i(fsel), .reset_interval_time_i(iv),
        .undervoltage_reset_policy_i(uvp), .torque_detect_select_ch1_i(sel1),
        .torque_detect_select_ch2_i(sel2), .torque_detect_level_ch1_i(lvl),
        .torque_detect_level_ch2_i(9'h12C), .torque_detect_time_ch1_i(7'h00),
        .torque_detect_time_ch2_i(7'h00), .output_terminal_function_sel0_i(8'h1E),
        .output_terminal_function_sel1_i(fn1), .output_terminal0_o(t0), .output_terminal1_o(t1),
        .drive_stop_o(stp), .fault_locked_o(lck), .reset_attempt_count_o(cnt),
        .overtorque_event_ch1_o(ov1), .overtorque_event_ch2_o(ov2),
        .undertorque_event_ch1_o(un1), .undertorque_event_ch2_o(un2));

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input string nm, input logic [3:0] s, input logic [3:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s: expected %0h, seen %0h", nm, e, s);
        end
    endtask

    task automatic report_and_stop();
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Bounded wait for the sequencer to go back to run
    task automatic wait_run();
        int n;
        n = 0;
        while (stp !== 1'b0 && n < 400) begin
            step(1);
            n++;
        end
        if (stp !== 1'b0) begin
            failures++;
            report_and_stop();
        end
    endtask

    task automatic manual();
        mrst = 1'b1;
        step(1);
        mrst = 1'b0;
        step(2);
    endtask

    initial begin
        {uv, oth, mrst, spd, vf, uvp, sel1, sel2, cur, trq, dir} = '0;
        run = 1'b1;
        lim = 4'h2;
        fn1 = 8'h0E;
        fsel = 1'($random(seed));
        iv = 13'({$random(seed)} % 4);
        lvl = 9'(20 + {$random(seed)} % 256);
        step(3);
        srst_i = 1'b0;
        step(2);
        chk("count", cnt, 4'h0);
        for (int k = 1; k <= 3; k++) begin
            dir = 1'($random(seed));
            rf[{$random(seed)} % 11] = 1'b1;
            step(4);
            chk("locked", lck, 4'(k == 3));
            if (k < 3) begin
                chk("resetting", t0, 1'b1);
                chk("fault out", t1, fsel);
            end
            rf = 11'h000;
            if (k < 3) wait_run();
            chk("count", cnt, 4'(k < 3 ? k : 2));
        end
        manual();
        chk("count", cnt, 4'h0);
        lim = 4'h0;
        for (int k = 0; k < 3; k++) begin
            {oth, uv, uvp} = {k == 0, k != 0, k == 2};
            step(4);
            chk("locked", lck, 4'(k != 2));
            {oth, uv} = 2'b00;
            if (k == 2) begin
                wait_run();
                chk("count", cnt, 4'h1);
                step(24010);
                chk("count", cnt, 4'h0);
            end
            manual();
            chk("locked", lck, 4'h0);
        end
        fn1 = 8'h0B;
        vf = 1'b1;
        trq = 10'h3FF;
        sel2 = 4'h6;
        for (int k = 0; k < 4; k++) begin
            sel1 = (k == 0) ? 4'h1 : 4'h2;
            cur = 10'(lvl) + off[k];
            step(12);
            chk("over 1", ov1, 4'(k == 1 || k == 2));
            chk("terminal 1", t1, 4'(k == 1 || k == 2));
            chk("under 2", un2, 4'h1);
            chk("over 2", ov2, 4'h0);
            chk("under 1", un1, 4'h0);
        end
        sel1 = 4'h3;
        spd = 1'b1;
        cur = 10'(lvl) + off[0];
        step(12);
        chk("locked", lck, 4'h1);
        chk("stopped", stp, 4'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
